// ---- rtl/pjd_consts.vh ----
// Shared constants for the paper jam detector
`ifndef PJD_CONSTS_VH
`define PJD_CONSTS_VH

// ==========================================================
// Clock and start-up timing
`define PJD_CLK_MHZ 25
`define PJD_SETTLE_W 3
`define PJD_SETTLE_CYC 3'h5

// ==========================================================
// Diagnostic jam codes
`define PJD_CODE_W 5
`define PJD_JAM_NONE 5'h00
`define PJD_JAM_PATH_REMAIN 5'h01
`define PJD_JAM_EXIT_REMAIN 5'h02
`define PJD_JAM_ENTRY_LATE 5'h03
`define PJD_JAM_ENTRY_STALL 5'h04
`define PJD_JAM_COVER_OPEN 5'h05
`define PJD_JAM_STAPLE 5'h06
`define PJD_JAM_STACK_EXIT 5'h07
`define PJD_JAM_MIDDLE_LATE 5'h08
`define PJD_JAM_MIDDLE_STALL 5'h09
`define PJD_JAM_SUB_LATE 5'h0a
`define PJD_JAM_SUB_STALL 5'h0b
`define PJD_JAM_SUB_REMAIN 5'h0c
`define PJD_JAM_PUNCH 5'h0d
`define PJD_JAM_STAPLE_SLIDE 5'h0e
`define PJD_JAM_EXIT_SHIFT 5'h0f

// ==========================================================
// Input bundle width
`define PJD_PIN_W 16

`endif

// ---- rtl/pjd_sync.v ----
// Three-stage pin synchroniser with agreement filter
module pjd_sync #(
  parameter W = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire [W-1:0] pin,
  output reg [W-1:0] level
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  // ==========================================================
  // Stage one feeds stage two only; level moves once two and three agree
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      level <= {W{1'b0}};
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

endmodule // pjd_sync

// ---- rtl/pjd_watch.v ----
// Armed tick counter that fires once a limit passes
module pjd_watch #(
  parameter CW = 12,
  parameter [CW-1:0] LIMIT = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire clear,
  input wire start,
  input wire tick,
  input wire stop,
  output reg expired
);

  reg armed;
  reg [CW-1:0] count;

  // ==========================================================
  // Clear and stop win over arming, so a halted path stays quiet
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      armed <= 1'b0;
      count <= {CW{1'b0}};
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (clear || stop)
        armed <= 1'b0;
      else if (start)
      begin
        armed <= 1'b1;
        count <= {CW{1'b0}};
      end
      else if (armed && tick)
      begin
        if (count == LIMIT - 1'b1)
        begin
          armed <= 1'b0;
          expired <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end

endmodule // pjd_watch

// ---- rtl/pjd_detector.v ----
// Jam supervision core for the sheet finisher and punch unit
//
// Summary of operation
// R1 - Any detected jam is reported to the host as a diagnostic code.
// R2 - Entrance or middle paper at power-up or cover close is a remaining jam.
// R3 - With punch fitted, punch paper at power-up or cover close also counts.
// R4 - Finishing tray paper at power-up is an exit outlet remaining jam.
// R5 - Entrance must see paper within a timeout after host sheet signal.
// R6 - Entrance must clear before first transport motor completes its step count.
// R7 - Front cover or sub-path cover open while running is a cover jam.
// R8 - With punch fitted, punch connection open is also a cover jam.
// R9 - Clinch fault sensor reporting stapling impossible is a stapling jam.
// R10 - Clinch must reopen in time; opening during reverse is also a jam.
// R11 - Staple ejection must see staple ready, else stapling jam.
// R12 - Tray must clear before exit motor completes its exit step count.
// R13 - Middle sensor must see paper within first motor step count.
// R14 - Middle sensor must clear within second motor step count.
// R15 - Sub-path sensor must see paper within set run time of both motors.
// R16 - Sub-path sensor must clear within second motor step count.
// R17 - Sub-path paper at power-up or cover close is a remaining jam.
// R18 - Punch shaft away from home at check time is a punching jam.
// R19 - Punch slide motor error while moving is a punching jam.
// R20 - Staple slide motor error while moving is flagged.
// R21 - Exit roller shift motor error while moving is flagged.
// R22 - Punch shaft sensor low means the puncher rests at home.
// R23 - Every timeout and step count is a module parameter.
// R24 - Jam code holds until acknowledge or cover close; sequencing halts.
`include "pjd_consts.vh"

module pjd_detector #(
  parameter SHEET_TIMEOUT_US = 1000,
  parameter SUBPATH_REACH_US = 2000,
  parameter CLINCH_OPEN_US = 500,
  parameter CYC_W = 24,
  parameter STEP_W = 12,
  parameter [STEP_W-1:0] ENTRY_STALL_STEPS = 12'h190,
  parameter [STEP_W-1:0] MIDDLE_REACH_STEPS = 12'h12c,
  parameter [STEP_W-1:0] MIDDLE_STALL_STEPS = 12'h190,
  parameter [STEP_W-1:0] SUBPATH_STALL_STEPS = 12'h190,
  parameter [STEP_W-1:0] STACK_EXIT_STEPS = 12'h258
) (
  input wire ref_clk,
  input wire rst,
  input wire entrance_path_sensor,
  input wire middle_path_sensor,
  input wire punch_paper_sensor,
  input wire finishing_tray_sensor,
  input wire subpath_sensor,
  input wire front_cover_switch,
  input wire subpath_cover_sensor,
  input wire clinch_fault_sensor,
  input wire clinch_home_sensor,
  input wire staple_ready_sensor,
  input wire punch_shaft_home_sensor,
  input wire punch_connect_open,
  input wire punch_fitted,
  input wire punch_slide_motor_error,
  input wire staple_slide_motor_error,
  input wire exit_roller_shift_motor_error,
  input wire finisher_running,
  input wire sheet_coming,
  input wire first_transport_motor_step,
  input wire second_transport_motor_step,
  input wire first_transport_motor_run,
  input wire second_transport_motor_run,
  input wire stack_exit_motor_step,
  input wire stack_exit_motor_forward,
  input wire stack_eject_start,
  input wire stapling_active,
  input wire staple_reverse,
  input wire staple_eject_active,
  input wire punch_home_check,
  input wire punch_slide_moving,
  input wire staple_slide_moving,
  input wire exit_shift_moving,
  input wire jam_ack,
  output reg jam_valid,
  output reg [`PJD_CODE_W-1:0] jam_code,
  output reg sequencing_halt
);

  // ==========================================================
  // Derived cycle counts; a time too long for CYC_W bits wraps
  localparam integer SHEET_PROD = SHEET_TIMEOUT_US * `PJD_CLK_MHZ;
  localparam integer SUB_REACH_PROD = SUBPATH_REACH_US * `PJD_CLK_MHZ;
  localparam integer CLINCH_PROD = CLINCH_OPEN_US * `PJD_CLK_MHZ;
  localparam [CYC_W-1:0] SHEET_CYC = SHEET_PROD[CYC_W-1:0]; // R23
  localparam [CYC_W-1:0] SUB_REACH_CYC = SUB_REACH_PROD[CYC_W-1:0]; // R23
  localparam [CYC_W-1:0] CLINCH_CYC = CLINCH_PROD[CYC_W-1:0]; // R23

  wire [`PJD_PIN_W-1:0] pin_raw;
  wire [`PJD_PIN_W-1:0] pin_sync;
  wire s_entry;
  wire s_middle;
  wire s_punch_paper;
  wire s_tray;
  wire s_sub;
  wire s_front_open;
  wire s_sub_cover_open;
  wire s_clinch_fault;
  wire s_clinch_closed;
  wire s_staple_ready;
  wire s_shaft_away;
  wire s_punch_conn_open;
  wire s_punch_fitted;
  wire s_punch_slide_err;
  wire s_staple_slide_err;
  wire s_exit_shift_err;

  // ==========================================================
  // Pin inputs pass the three-stage synchroniser as one bundle
  assign pin_raw = {entrance_path_sensor, middle_path_sensor, punch_paper_sensor,
    finishing_tray_sensor, subpath_sensor, front_cover_switch, subpath_cover_sensor,
    clinch_fault_sensor, clinch_home_sensor, staple_ready_sensor,
    punch_shaft_home_sensor, punch_connect_open, punch_fitted,
    punch_slide_motor_error, staple_slide_motor_error, exit_roller_shift_motor_error};

  pjd_sync #(
    .W(`PJD_PIN_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(pin_raw),
    .level(pin_sync)
  );

  assign {s_entry, s_middle, s_punch_paper, s_tray, s_sub, s_front_open,
    s_sub_cover_open, s_clinch_fault, s_clinch_closed, s_staple_ready,
    s_shaft_away, s_punch_conn_open, s_punch_fitted, s_punch_slide_err,
    s_staple_slide_err, s_exit_shift_err} = pin_sync; // R22

  // ==========================================================
  // Previous levels for edge detection
  reg prev_entry;
  reg prev_middle;
  reg prev_sub;
  reg prev_front_open;
  reg prev_clinch_closed;
  reg prev_eject;
  reg prev_reverse_open;
  reg ready_seen;
  reg [`PJD_SETTLE_W-1:0] settle;
  reg powerup_check;

  wire entry_rise;
  wire entry_fall;
  wire middle_rise;
  wire middle_fall;
  wire sub_rise;
  wire sub_fall;
  wire cover_closed;
  wire clinch_close;
  wire clinch_open;
  wire eject_end;
  wire reverse_open;

  assign entry_rise = s_entry & ~prev_entry;
  assign entry_fall = ~s_entry & prev_entry;
  assign middle_rise = s_middle & ~prev_middle;
  assign middle_fall = ~s_middle & prev_middle;
  assign sub_rise = s_sub & ~prev_sub;
  assign sub_fall = ~s_sub & prev_sub;
  assign cover_closed = ~s_front_open & prev_front_open;
  assign clinch_close = stapling_active & s_clinch_closed & ~prev_clinch_closed;
  assign clinch_open = ~s_clinch_closed;
  assign eject_end = ~staple_eject_active & prev_eject;
  assign reverse_open = staple_reverse & clinch_open;

  // Edge history; power-up check waits until the synchroniser has filled
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_entry <= 1'b0;
      prev_middle <= 1'b0;
      prev_sub <= 1'b0;
      prev_front_open <= 1'b0;
      prev_clinch_closed <= 1'b0;
      prev_eject <= 1'b0;
      prev_reverse_open <= 1'b0;
      ready_seen <= 1'b0;
      settle <= {`PJD_SETTLE_W{1'b0}};
      powerup_check <= 1'b0;
    end
    else
    begin
      prev_entry <= s_entry;
      prev_middle <= s_middle;
      prev_sub <= s_sub;
      prev_front_open <= s_front_open;
      prev_clinch_closed <= s_clinch_closed;
      prev_eject <= staple_eject_active;
      prev_reverse_open <= reverse_open;
      powerup_check <= (settle == `PJD_SETTLE_CYC - 1'b1);
      if (settle != `PJD_SETTLE_CYC)
        settle <= settle + 1'b1;
      // Ready seen reloads from the ready sensor at each new ejection
      if (staple_eject_active && !prev_eject)
        ready_seen <= s_staple_ready;
      else if (staple_eject_active && s_staple_ready)
        ready_seen <= 1'b1;
    end
  end

  // ==========================================================
  // Travel watchers; all are cleared while a jam is held
  wire w_entry_late;
  wire w_entry_stall;
  wire w_middle_late;
  wire w_middle_stall;
  wire w_sub_late;
  wire w_sub_stall;
  wire w_stack_exit;
  wire w_clinch;

  pjd_watch #(.CW(CYC_W), .LIMIT(SHEET_CYC)) u_entry_late (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid), // R24
    .start(sheet_coming), .tick(1'b1), .stop(entry_rise), // R5
    .expired(w_entry_late)
  );

  pjd_watch #(.CW(STEP_W), .LIMIT(ENTRY_STALL_STEPS)) u_entry_stall (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(entry_rise), .tick(first_transport_motor_step), // R6
    .stop(entry_fall), .expired(w_entry_stall)
  );

  pjd_watch #(.CW(STEP_W), .LIMIT(MIDDLE_REACH_STEPS)) u_middle_late (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(entry_rise), .tick(first_transport_motor_step), // R13
    .stop(middle_rise), .expired(w_middle_late)
  );

  pjd_watch #(.CW(STEP_W), .LIMIT(MIDDLE_STALL_STEPS)) u_middle_stall (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(middle_rise), .tick(second_transport_motor_step), // R14
    .stop(middle_fall), .expired(w_middle_stall)
  );

  // Run time counts only cycles in which both transport motors turn
  pjd_watch #(.CW(CYC_W), .LIMIT(SUB_REACH_CYC)) u_sub_late (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(entry_rise), // R15
    .tick(first_transport_motor_run & second_transport_motor_run), // R15
    .stop(sub_rise), .expired(w_sub_late)
  );

  pjd_watch #(.CW(STEP_W), .LIMIT(SUBPATH_STALL_STEPS)) u_sub_stall (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(sub_rise), .tick(second_transport_motor_step), // R16
    .stop(sub_fall), .expired(w_sub_stall)
  );

  // Steps in the reverse direction do not advance the stack exit count
  pjd_watch #(.CW(STEP_W), .LIMIT(STACK_EXIT_STEPS)) u_stack_exit (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(stack_eject_start), // R12
    .tick(stack_exit_motor_step & stack_exit_motor_forward), // R12
    .stop(~s_tray & ~stack_eject_start), .expired(w_stack_exit)
  );

  pjd_watch #(.CW(CYC_W), .LIMIT(CLINCH_CYC)) u_clinch (
    .ref_clk(ref_clk), .rst(rst), .clear(jam_valid),
    .start(clinch_close), .tick(1'b1), // R10
    .stop(clinch_open), .expired(w_clinch)
  );

  // ==========================================================
  // Level and instant jam conditions
  wire remain_check;
  wire det_path_remain;
  wire det_exit_remain;
  wire det_sub_remain;
  wire det_cover;
  wire det_staple;
  wire det_punch;
  wire det_staple_slide;
  wire det_exit_shift;

  assign remain_check = powerup_check | cover_closed;
  assign det_path_remain = remain_check & (s_entry | s_middle | // R2
    (s_punch_fitted & s_punch_paper)); // R3
  assign det_exit_remain = powerup_check & s_tray; // R4
  assign det_sub_remain = remain_check & s_sub; // R17
  assign det_cover = (finisher_running & (s_front_open | s_sub_cover_open)) | // R7
    (s_punch_fitted & s_punch_conn_open); // R8
  assign det_staple = s_clinch_fault | // R9
    w_clinch | (reverse_open & ~prev_reverse_open) | // R10
    (eject_end & ~ready_seen); // R11
  // Sensor high means the shaft is away from home at check time
  assign det_punch = s_punch_fitted & ((punch_home_check & s_shaft_away) | // R18
    (punch_slide_moving & s_punch_slide_err)); // R19
  assign det_staple_slide = staple_slide_moving & s_staple_slide_err; // R20
  assign det_exit_shift = exit_shift_moving & s_exit_shift_err; // R21

  // ==========================================================
  // Fixed priority picks one code when several fire together
  reg [`PJD_CODE_W-1:0] next_code;

  always @*
  begin
    next_code = `PJD_JAM_NONE;
    if (det_cover)
      next_code = `PJD_JAM_COVER_OPEN;
    else if (det_path_remain)
      next_code = `PJD_JAM_PATH_REMAIN;
    else if (det_exit_remain)
      next_code = `PJD_JAM_EXIT_REMAIN;
    else if (det_sub_remain)
      next_code = `PJD_JAM_SUB_REMAIN;
    else if (w_entry_late)
      next_code = `PJD_JAM_ENTRY_LATE;
    else if (w_entry_stall)
      next_code = `PJD_JAM_ENTRY_STALL;
    else if (w_middle_late)
      next_code = `PJD_JAM_MIDDLE_LATE;
    else if (w_middle_stall)
      next_code = `PJD_JAM_MIDDLE_STALL;
    else if (w_sub_late)
      next_code = `PJD_JAM_SUB_LATE;
    else if (w_sub_stall)
      next_code = `PJD_JAM_SUB_STALL;
    else if (w_stack_exit)
      next_code = `PJD_JAM_STACK_EXIT;
    else if (det_staple)
      next_code = `PJD_JAM_STAPLE;
    else if (det_punch)
      next_code = `PJD_JAM_PUNCH;
    else if (det_staple_slide)
      next_code = `PJD_JAM_STAPLE_SLIDE;
    else if (det_exit_shift)
      next_code = `PJD_JAM_EXIT_SHIFT;
  end

  // ==========================================================
  // Jam latch: first jam holds; a new jam in the clearing cycle wins
  wire jam_release;

  assign jam_release = jam_ack | cover_closed; // R24

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      jam_valid <= 1'b0;
      jam_code <= `PJD_JAM_NONE;
      sequencing_halt <= 1'b0;
    end
    else if ((!jam_valid || jam_release) && next_code != `PJD_JAM_NONE)
    begin
      jam_valid <= 1'b1; // R1
      jam_code <= next_code; // R1
      sequencing_halt <= 1'b1; // R24
    end
    else if (jam_release)
    begin
      jam_valid <= 1'b0; // R24
      jam_code <= `PJD_JAM_NONE;
      sequencing_halt <= 1'b0;
    end
  end

endmodule // pjd_detector

// ---- bench/pjd_host.sv ----
// Host controller model: announces sheets and acknowledges jam codes
module pjd_host (
  input wire ref_clk,
  input wire rst,
  input wire announce,
  input wire ack_req,
  input wire [3:0] ack_wait,
  input wire [4:0] jam_code,
  output logic sheet_coming,
  output logic jam_ack,
  output logic [4:0] seen_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic busy;

  // ==========================================
  // Sheet notice and acknowledge ack_wait plus one cycles after the request, so slow hosts are covered
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      sheet_coming <= 1'b0;
      jam_ack <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      seen_code <= 5'h00;
    end
    else
    begin
      sheet_coming <= announce;
      jam_ack <= 1'b0;
      if (ack_req)
      begin
        busy <= 1'b1;
        cnt <= ack_wait;
      end
      else if (busy && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        jam_ack <= 1'b1;
        seen_code <= jam_code;
      end
    end
endmodule // pjd_host

// ---- bench/pjd_detector_properties.sv ----
// Port checker for the jam detector
module pjd_detector_properties #(
  parameter SHEET_TIMEOUT_US = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire entrance_path_sensor,
  input wire front_cover_switch,
  input wire clinch_fault_sensor,
  input wire punch_connect_open,
  input wire staple_slide_motor_error,
  input wire exit_roller_shift_motor_error,
  input wire finisher_running,
  input wire sheet_coming,
  input wire staple_slide_moving,
  input wire exit_shift_moving,
  input wire jam_ack,
  input wire jam_valid,
  input wire [4:0] jam_code,
  input wire sequencing_halt
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LATE_LO = SHEET_TIMEOUT_US * 25 - 10;
  localparam int LATE_HI = SHEET_TIMEOUT_US * 25 + 5;
  logic [3:0] since_rst;
  logic [3:0] ent_hi = 4'h0;
  logic [3:0] cov_lo = 4'h0;
  logic [3:0] xerr_cnt = 4'h0;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========================================
  // Helper counters, saturating so long runs never wrap
  always @(posedge ref_clk or posedge rst)
    if (rst)
      since_rst <= 4'h0;
    else
      since_rst <= since_rst + {3'h0, since_rst != 4'hf};
  // Pin histories start at zero and ignore reset: the boot check needs pins held through it
  always @(posedge ref_clk)
  begin
    ent_hi <= entrance_path_sensor ? ent_hi + {3'h0, ent_hi != 4'hf} : 4'h0;
    cov_lo <= !front_cover_switch ? cov_lo + {3'h0, cov_lo != 4'hf} : 4'h0;
    xerr_cnt <= (exit_shift_moving && exit_roller_shift_motor_error) ?
      xerr_cnt + {3'h0, xerr_cnt != 4'hf} : 4'h0;
  end

  // ==========================================
  // Properties
  sequence s_no_entry;
    sheet_coming && !jam_valid && !entrance_path_sensor ##1 !entrance_path_sensor [*8];
  endsequence
  sequence s_late_code;
    jam_valid && jam_code == 5'h03;
  endsequence

  a_halt_tracks: assert property (sequencing_halt == jam_valid)
    else $error("halt differs from jam valid");
  a_code_valid: assert property ((jam_code != 5'h00) == jam_valid)
    else $error("jam code and valid disagree");
  a_code_holds: assert property (jam_valid && !jam_ack && cov_lo == 4'hf |=>
    jam_valid && $stable(jam_code))
    else $error("held jam code changed");
  a_entry_late: assert property (s_no_entry |-> ##[LATE_LO:LATE_HI] s_late_code)
    else $error("late sheet not flagged");
  a_cover_open: assert property ((finisher_running && front_cover_switch) [*7] |-> jam_valid)
    else $error("open cover not flagged");
  a_clinch_fault: assert property ($rose(clinch_fault_sensor) |-> ##[2:7] jam_valid)
    else $error("clinch fault not flagged");
  a_slide_error: assert property ((staple_slide_moving && staple_slide_motor_error) [*6]
    |=> jam_valid)
    else $error("staple slide error not flagged");
  a_shift_error: assert property (xerr_cnt == 4'h7 |-> jam_valid)
    else $error("exit shift error not flagged");
  a_remain_boot: assert property (since_rst == 4'h8 && ent_hi == 4'hf && !finisher_running
    && !punch_connect_open |-> jam_valid && jam_code == 5'h01)
    else $error("boot remaining paper not flagged");
endmodule // pjd_detector_properties

bind pjd_detector pjd_detector_properties #(.SHEET_TIMEOUT_US(SHEET_TIMEOUT_US)) u_props (
  .ref_clk, .rst, .entrance_path_sensor, .front_cover_switch, .clinch_fault_sensor,
  .punch_connect_open, .staple_slide_motor_error, .exit_roller_shift_motor_error,
  .finisher_running, .sheet_coming, .staple_slide_moving, .exit_shift_moving, .jam_ack,
  .jam_valid, .jam_code, .sequencing_halt);

// ---- bench/pjd_detector_tb_top.sv ----
// Self-checking bench for the jam detector
module pjd_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Level bits: 0 run 1 fcov 2 scov 3 fit 4 conn 5 cfault 6 pmov 7 perr 8 smov 9 serr
  // 10 xmov 11 xerr 12 ent 13 mid 14 ppap 15 tray 16 sub 17 chome 18 ready 19 shaft
  // 20 run1 21 run2 22 fwd 23 stapling 24 rev 25 eject
  // Pulse bits: 0 announce 1 step1 2 step2 3 step3 4 eject start 5 home check 6 ack
  logic ref_clk;
  logic rst;
  logic [25:0] lv;
  logic [6:0] pv;
  logic [3:0] host_wait;
  wire sheet_coming;
  wire jam_ack;
  wire jam_valid;
  wire sequencing_halt;
  wire [4:0] jam_code;
  wire [4:0] seen_code;
  int n_mismatch;
  int checks;
  localparam logic [30:0] ROWS [9] = '{
    {5'h05, 26'h0000003}, {5'h05, 26'h0000005}, {5'h05, 26'h0000018},
    {5'h00, 26'h0000010}, {5'h06, 26'h0000020}, {5'h0d, 26'h00000c8},
    {5'h0e, 26'h0000300}, {5'h00, 26'h0000200}, {5'h0f, 26'h0000c00}};
  localparam logic [30:0] CLOSE [2] = '{{5'h0c, 26'h0010000}, {5'h01, 26'h0004008}};
  localparam int STALL_STEPS = 400; // Design default of all three stall counts

  // ==========================================
  // Design, host model and clock
  // Stall counts keep their defaults; timed limits are shortened for run time
  pjd_detector #(.SHEET_TIMEOUT_US(1), .SUBPATH_REACH_US(1), .CLINCH_OPEN_US(1),
    .MIDDLE_REACH_STEPS(12'h003), .STACK_EXIT_STEPS(12'h006)) DUT (
    .ref_clk(ref_clk), .rst(rst), .finisher_running(lv[0]), .front_cover_switch(lv[1]),
    .subpath_cover_sensor(lv[2]), .punch_fitted(lv[3]), .punch_connect_open(lv[4]),
    .clinch_fault_sensor(lv[5]), .punch_slide_moving(lv[6]), .punch_slide_motor_error(lv[7]),
    .staple_slide_moving(lv[8]), .staple_slide_motor_error(lv[9]), .exit_shift_moving(lv[10]),
    .exit_roller_shift_motor_error(lv[11]), .entrance_path_sensor(lv[12]),
    .middle_path_sensor(lv[13]), .punch_paper_sensor(lv[14]), .finishing_tray_sensor(lv[15]),
    .subpath_sensor(lv[16]), .clinch_home_sensor(lv[17]), .staple_ready_sensor(lv[18]),
    .punch_shaft_home_sensor(lv[19]), .first_transport_motor_run(lv[20]),
    .second_transport_motor_run(lv[21]), .stack_exit_motor_forward(lv[22]),
    .stapling_active(lv[23]), .staple_reverse(lv[24]), .staple_eject_active(lv[25]),
    .sheet_coming(sheet_coming), .first_transport_motor_step(pv[1]),
    .second_transport_motor_step(pv[2]), .stack_exit_motor_step(pv[3]),
    .stack_eject_start(pv[4]), .punch_home_check(pv[5]), .jam_ack(jam_ack),
    .jam_valid(jam_valid), .jam_code(jam_code), .sequencing_halt(sequencing_halt));
  pjd_host u_host (.ref_clk(ref_clk), .rst(rst), .announce(pv[0]), .ack_req(pv[6]),
    .ack_wait(host_wait), .jam_code(jam_code), .sheet_coming(sheet_coming),
    .jam_ack(jam_ack), .seen_code(seen_code));
  // Free-running 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // ==========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [6:0] m, input int n);
    repeat (n)
    begin
      pv <= m;
      @(posedge ref_clk);
      pv <= 7'h00;
      @(posedge ref_clk);
    end
  endtask
  task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a jam, then code, valid and halt are compared off the edge
  task automatic expect_jam(input logic [4:0] exp);
    int i;
    if (exp === 5'h00)
      cyc(12);
    else
      for (i = 0; i < 60 && jam_valid !== 1'b1; i++)
        cyc(1);
    #1;
    cmp(jam_code, exp);
    cmp({3'h0, jam_valid, sequencing_halt}, (exp === 5'h00) ? 5'h00 : 5'h03);
    @(posedge ref_clk);
  endtask
  // Causes drop first, so level causes cannot re-latch after the ack
  task automatic clear_jam();
    lv <= 26'h0;
    cyc(8);
    pulse(7'h40, 1);
    cyc(6);
    expect_jam(5'h00);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // Main sequence: paper at entrance held through reset
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    lv = 26'h0001000;
    pv = 7'h00;
    host_wait = 4'h0;
    n_mismatch = 0;
    checks = 0;
    cyc(12);
    rst <= 1'b0;
    expect_jam(5'h01);
    clear_jam();
    for (int i = 0; i < 9; i++)
    begin
      lv <= ROWS[i][25:0];
      expect_jam(ROWS[i][30:26]);
      clear_jam();
    end
    for (int i = 0; i < 2; i++)
    begin
      lv <= CLOSE[i][25:0] | 26'h0000002;
      cyc(8);
      lv <= CLOSE[i][25:0];
      expect_jam(CLOSE[i][30:26]);
      clear_jam();
    end
    host_wait <= 4'h3;
    pulse(7'h01, 1);
    expect_jam(5'h03);
    lv <= 26'h0000020;
    cyc(10);
    expect_jam(5'h03);
    clear_jam();
    cmp(seen_code, 5'h03);
    lv <= 26'h0003000;
    cyc(6);
    pulse(7'h02, STALL_STEPS - 1);
    expect_jam(5'h00);
    pulse(7'h02, 1);
    expect_jam(5'h04);
    clear_jam();
    lv <= 26'h0001000;
    cyc(6);
    pulse(7'h02, 3);
    expect_jam(5'h08);
    clear_jam();
    lv <= 26'h0003000;
    cyc(6);
    lv <= 26'h0002000;
    cyc(6);
    pulse(7'h04, STALL_STEPS - 1);
    expect_jam(5'h00);
    pulse(7'h04, 1);
    expect_jam(5'h09);
    clear_jam();
    lv <= 26'h0303000;
    expect_jam(5'h0a);
    clear_jam();
    lv <= 26'h0010000;
    cyc(6);
    pulse(7'h04, STALL_STEPS);
    expect_jam(5'h0b);
    clear_jam();
    lv <= 26'h0008000;
    cyc(6);
    pulse(7'h10, 1);
    pulse(7'h08, 8);
    expect_jam(5'h00);
    lv <= 26'h0408000;
    pulse(7'h08, 6);
    expect_jam(5'h07);
    clear_jam();
    lv <= 26'h0820000;
    expect_jam(5'h06);
    clear_jam();
    lv <= 26'h0020000;
    cyc(6);
    lv <= 26'h1020000;
    expect_jam(5'h00);
    lv <= 26'h1000000;
    expect_jam(5'h06);
    clear_jam();
    lv <= 26'h2000000;
    cyc(4);
    lv <= 26'h0;
    expect_jam(5'h06);
    clear_jam();
    lv <= 26'h2040000;
    cyc(6);
    lv <= 26'h0;
    expect_jam(5'h00);
    lv <= 26'h0080008;
    cyc(6);
    pulse(7'h20, 1);
    expect_jam(5'h0d);
    clear_jam();
    lv <= 26'h0000008;
    cyc(6);
    pulse(7'h20, 1);
    expect_jam(5'h00);
    lv <= 26'h0008000;
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    expect_jam(5'h02);
    clear_jam();
    close_out();
  end

  // Watchdog, far beyond the few thousand cycles the sequence needs
  initial
  begin
    cyc(20000);
    n_mismatch++;
    close_out();
  end
endmodule // pjd_detector_tb_top
